//--- logic/ibr_pkg.sv
// Shared constants for the bridge latency, APIC and DMA configuration slice.
package ibr_pkg;
  // Configuration byte offsets of each register.
  localparam logic [7:0] OFF_MISC     = 8'h6A;
  localparam logic [7:0] OFF_MBCTL0   = 8'h76;
  localparam logic [7:0] OFF_MBCTL1   = 8'h77;
  localparam logic [7:0] OFF_APIC     = 8'h80;
  localparam logic [7:0] OFF_LAT      = 8'h82;
  localparam logic [7:0] OFF_DTYPE    = 8'h90;
  localparam logic [7:0] OFF_DBASE_LO = 8'h92;
  localparam logic [7:0] OFF_DBASE_HI = 8'h94;

  // Reset values.
  localparam logic [7:0]  RST_MBCTL = 8'h04;
  localparam logic [7:0]  RST_APIC  = 8'h00;
  localparam logic [7:0]  RST_LAT   = 8'h00;
  localparam logic [15:0] RST_W16   = 16'h0000;

  // Writable bits; every other bit is reserved and reads as zero, except the sticky error bit 15 of MISC.
  localparam logic [7:0]  WM_MBCTL = 8'h87;
  localparam logic [7:0]  WM_APIC  = 8'h7F;
  localparam logic [7:0]  WM_LAT   = 8'h0F;
  localparam logic [15:0] WM_DTYPE = 16'hFCFF;
  localparam logic [15:0] WM_DBASE = 16'hFFC0;
  localparam logic [15:0] WM_MISC  = 16'h0080;

  // Field positions.
  localparam int MB_EN_BIT     = 7;
  localparam int APIC_MASK_BIT = 6;
  localparam int LAT_DT_BIT    = 0;
  localparam int LAT_PR_BIT    = 1;
  localparam int LAT_USB_BIT   = 2;
  localparam int LAT_SERR_BIT  = 3;
  localparam int MISC_ERR_BIT  = 15;

  // Motherboard DMA routing codes.
  localparam logic [2:0] ROUTE_OFF = 3'h4;

  // Per-channel DMA protocol.
  localparam logic [1:0] DT_ISA  = 2'h0;
  localparam logic [1:0] DT_SIDE = 2'h1;
  localparam logic [1:0] DT_DIST = 2'h2;

  // APIC window base and distributed DMA cascade channel.
  localparam logic [15:0] APIC_HI   = 16'hFEC0;
  localparam logic [2:0]  CASCADE   = 3'h4;

  // Latency limits in PCI clocks and discard timeout.
  localparam logic [4:0] TGT_LAT_CLKS = 5'h10;
  localparam logic [3:0] MST_LAT_CLKS = 4'h8;
  localparam int         DISCARD_CLKS = 32768;
endpackage

//--- logic/ibr_route_dec.sv
// Decoder from one motherboard DMA control byte to a channel enable vector.
`timescale 1ns/1ps
module ibr_route_dec (
  input  wire logic [7:0] ctrl_i,   // Control register contents.
  output logic      [7:0] ch_en_o   // One-hot fast channel enable.
);
  // Only channels 0, 1, 2, 5 and 6 are routable; other codes enable nothing.
  always_comb
  begin
    ch_en_o = 8'h00;
    if (ctrl_i[ibr_pkg::MB_EN_BIT])                          // RULE_01
    begin
      case (ctrl_i[2:0])                                     // RULE_02
        3'h0, 3'h1, 3'h2, 3'h5, 3'h6: ch_en_o[ctrl_i[2:0]] = 1'b1;
        default: ch_en_o = 8'h00;
      endcase
    end
  end
endmodule // ibr_route_dec

//--- logic/ibr_discard_tmr.sv
// Discard timer for one outstanding delayed transaction.
`timescale 1ns/1ps
module ibr_discard_tmr #(
  parameter int LIMIT = 32768               // Clocks allowed before discard.
) (
  input  wire logic sys_clk_i,              // PCI clock.
  input  wire logic rstn_i,                 // Async reset, active low.
  input  wire logic arm_i,                  // Transaction queued as delayed.
  input  wire logic clr_i,                  // Master retried or cancelled.
  output logic      busy_o,                 // Timer is running.
  output logic      expire_o                // One-cycle expiry pulse.
);
  localparam int W = $clog2(LIMIT + 1) + 1;
  logic [W-1:0] cnt_r, cnt_nxt;
  logic         run_r, run_nxt, exp_nxt;

  // Expiry fires once the count passes the limit, not on reaching it.
  always_comb
  begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    exp_nxt = 1'b0;
    if (clr_i)
    begin
      run_nxt = 1'b0;
      cnt_nxt = '0;
    end
    else if (arm_i)
    begin
      run_nxt = 1'b1;
      cnt_nxt = '0;
    end
    else if (run_r)
    begin
      cnt_nxt = cnt_r + 1'b1;
      if (cnt_r == W'(LIMIT))                                 // RULE_07
      begin
        exp_nxt = 1'b1;
        run_nxt = 1'b0;
      end
    end
  end

  // State registers.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_r    <= '0;
      run_r    <= 1'b0;
      expire_o <= 1'b0;
    end
    else
    begin
      cnt_r    <= cnt_nxt;
      run_r    <= run_nxt;
      expire_o <= exp_nxt;
    end
  end

  assign busy_o = run_r;
endmodule // ibr_discard_tmr

//--- logic/ibr_cfg_slice.sv
// Bridge configuration slice: fast DMA, APIC select, latency, DMA protocol.
`timescale 1ns/1ps
// Overview of operation
// RULE_01: Control byte top bit enables fast type F timing for its routed channel.
// RULE_02: Routing codes 0,1,2,5,6 pick that channel; code 4 means disabled.
// RULE_03: APIC register bits 5:2 match address bits 15:12.
// RULE_04: APIC register bits 1:0 match address bits 11:10, 1 KB steps.
// RULE_05: Mask bit 6 ignores address bit 12, selecting two ranges.
// RULE_06: Latency bit 0 turns on delayed transactions as target.
// RULE_07: Discard timer expires after more than 32768 clocks without retry.
// RULE_08: Latency bit 3 lets discard expiry raise system error.
// RULE_09: Latency bit 1 enables passive release on the hold request line.
// RULE_10: Latency bit 2 extends passive release to USB accesses.
// RULE_11: ISA masters honour ready wait; no guaranteed access with release.
// RULE_12: Target answers within 16 clocks; master ready within 8.
// RULE_13: Type field 0 ISA, 1 sideband, 2 distributed, 3 reserved.
// RULE_14: Type fields for channels 0-3 low byte, 5-7 upper, 9:8 reserved.
// RULE_15: Distributed channels ignore ISA and sideband requests.
// RULE_16: Base pointers hold address bits 15:6, low bits read zero.
// RULE_17: Each base opens 64 bytes, 16 per channel.
// RULE_18: Cascade channel 4 is never reachable through the window.
// RULE_19: System error from discard expiry sets sticky bit 15, write one clears.
// RULE_20: Reserved bits read zero, ignore writes; all registers reset.
module ibr_cfg_slice #(
  parameter int DISCARD_CLKS = ibr_pkg::DISCARD_CLKS // Discard timeout.
) (
  input  wire logic        sys_clk_i,           // PCI clock.
  input  wire logic        rstn_i,              // Bridge reset, active low.
  input  wire logic        cfg_wr_i,            // Config write strobe.
  input  wire logic        cfg_rd_i,            // Config read strobe.
  input  wire logic [7:0]  cfg_addr_i,          // Config byte address.
  input  wire logic [3:0]  cfg_be_i,            // Config byte enables.
  input  wire logic [31:0] cfg_wdata_i,         // Config write data.
  output logic      [31:0] cfg_rdata_o,         // Config read data.
  output logic             cfg_rvalid_o,        // Read data valid pulse.
  input  wire logic        mem_cycle_i,         // PCI memory address phase.
  input  wire logic [31:0] pci_addr_i,          // PCI address.
  output logic             ioapic_chip_select_n_o, // APIC select, low.
  input  wire logic        io_cycle_i,          // PCI I/O address phase.
  output logic             ddma_hit_o,          // Distributed window hit.
  output logic      [2:0]  ddma_chan_o,         // Channel of the hit.
  input  wire logic [7:0]  isa_dreq_i,          // ISA DMA requests.
  input  wire logic [7:0]  side_req_i,          // Sideband DMA requests.
  output logic      [7:0]  isa_dreq_gated_o,    // Requests kept.
  output logic      [7:0]  side_req_gated_o,    // Requests kept.
  output logic      [7:0]  fast_dma_en_o,       // Fast type F per channel.
  output logic      [15:0] dma_type_o,          // Protocol per channel.
  input  wire logic        tgt_frame_i,         // Frame start, targets us.
  input  wire logic        tgt_data_ok_i,       // Target data available.
  output logic             tgt_trdy_o,          // Target ready pulse.
  output logic             tgt_stop_o,          // Target retry pulse.
  output logic             delayed_en_o,        // Delayed mode active.
  input  wire logic        mst_phase_i,         // Master data phase.
  input  wire logic        mst_data_ok_i,       // Master data available.
  output logic             mst_irdy_o,          // Initiator ready.
  input  wire logic        hold_req_i,          // Bridge wants the bus.
  input  wire logic        usb_access_i,        // Access carries USB data.
  output logic             bridge_hold_request_n_o, // Hold line, low.
  output logic             passive_release_o,   // Passive release coded.
  output logic             serr_n_o             // System error, low.
);
  typedef enum logic [2:0] {
    T_IDLE  = 3'b001,
    T_WAIT  = 3'b010,
    T_PEND  = 3'b100
  } ibr_tgt_t;

  // Register file.
  logic [7:0]  mb0_r, mb0_nxt, mb1_r, mb1_nxt, apic_r, apic_nxt;
  logic [7:0]  lat_r, lat_nxt;
  logic [15:0] dtype_r, dtype_nxt, blo_r, blo_nxt, bhi_r, bhi_nxt;
  logic [15:0] misc_r, misc_nxt;
  logic [31:0] rd_nxt;
  logic        tmr_busy, tmr_exp;

  // True when a config write covers the byte at off.
  function automatic logic lane_hit(input logic [7:0] a, input logic [3:0] be,
                                    input logic [7:0] off);
    return cfg_wr_i && (a[7:2] == off[7:2]) && be[off[1:0]];
  endfunction

  // Byte of the write data that belongs to off.
  function automatic logic [7:0] wbyte(input logic [31:0] d,
                                       input logic [7:0] off);
    return d[{off[1:0], 3'b000} +: 8];
  endfunction

  // Two-bit protocol field of one channel.
  function automatic logic [1:0] ch_type(input logic [15:0] t,
                                         input int ch);
    return t[2*ch +: 2];
  endfunction

  // Register writes; reserved bits are masked away on the way in.
  always_comb
  begin
    mb0_nxt   = mb0_r;
    mb1_nxt   = mb1_r;
    apic_nxt  = apic_r;
    lat_nxt   = lat_r;
    dtype_nxt = dtype_r;
    blo_nxt   = blo_r;
    bhi_nxt   = bhi_r;
    misc_nxt  = misc_r;
    if (lane_hit(cfg_addr_i, cfg_be_i, ibr_pkg::OFF_MBCTL0))
      mb0_nxt = wbyte(cfg_wdata_i, ibr_pkg::OFF_MBCTL0) & ibr_pkg::WM_MBCTL;
    if (lane_hit(cfg_addr_i, cfg_be_i, ibr_pkg::OFF_MBCTL1))
      mb1_nxt = wbyte(cfg_wdata_i, ibr_pkg::OFF_MBCTL1) & ibr_pkg::WM_MBCTL;
    if (lane_hit(cfg_addr_i, cfg_be_i, ibr_pkg::OFF_APIC))
      apic_nxt = wbyte(cfg_wdata_i, ibr_pkg::OFF_APIC) & ibr_pkg::WM_APIC;
    if (lane_hit(cfg_addr_i, cfg_be_i, ibr_pkg::OFF_LAT))
      lat_nxt = wbyte(cfg_wdata_i, ibr_pkg::OFF_LAT) & ibr_pkg::WM_LAT;
    // Sixteen-bit registers take each byte lane separately.
    for (int b = 0; b < 2; b++)
    begin
      if (lane_hit(cfg_addr_i, cfg_be_i, ibr_pkg::OFF_DTYPE + 8'(b)))
        dtype_nxt[8*b +: 8] = wbyte(cfg_wdata_i, ibr_pkg::OFF_DTYPE + 8'(b))
                              & ibr_pkg::WM_DTYPE[8*b +: 8];       // RULE_14
      if (lane_hit(cfg_addr_i, cfg_be_i, ibr_pkg::OFF_DBASE_LO + 8'(b)))
        blo_nxt[8*b +: 8] = wbyte(cfg_wdata_i, ibr_pkg::OFF_DBASE_LO + 8'(b))
                            & ibr_pkg::WM_DBASE[8*b +: 8];         // RULE_16
      if (lane_hit(cfg_addr_i, cfg_be_i, ibr_pkg::OFF_DBASE_HI + 8'(b)))
        bhi_nxt[8*b +: 8] = wbyte(cfg_wdata_i, ibr_pkg::OFF_DBASE_HI + 8'(b))
                            & ibr_pkg::WM_DBASE[8*b +: 8];         // RULE_16
      if (lane_hit(cfg_addr_i, cfg_be_i, ibr_pkg::OFF_MISC + 8'(b)))
      begin
        misc_nxt[8*b +: 8] = (misc_r[8*b +: 8] & ~ibr_pkg::WM_MISC[8*b +: 8])
          | (wbyte(cfg_wdata_i, ibr_pkg::OFF_MISC + 8'(b))
             & ibr_pkg::WM_MISC[8*b +: 8]);                        // RULE_20
        if (b == 1 && cfg_wdata_i[{ibr_pkg::OFF_MISC[1:0], 3'b000} + 5'd15])
          misc_nxt[ibr_pkg::MISC_ERR_BIT] = 1'b0;                 // RULE_19
      end
    end
    // A new error in the same cycle as the clear must survive.
    if (tmr_exp && lat_r[ibr_pkg::LAT_SERR_BIT])
      misc_nxt[ibr_pkg::MISC_ERR_BIT] = 1'b1;                    // RULE_19
  end

  // Read mux; unmapped bytes and reserved bits return zero.
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (cfg_addr_i[7:2] == ibr_pkg::OFF_MISC[7:2])
      rd_nxt[{ibr_pkg::OFF_MISC[1:0], 3'b000} +: 16] = misc_r;
    if (cfg_addr_i[7:2] == ibr_pkg::OFF_MBCTL0[7:2])
    begin
      rd_nxt[{ibr_pkg::OFF_MBCTL0[1:0], 3'b000} +: 8] = mb0_r;
      rd_nxt[{ibr_pkg::OFF_MBCTL1[1:0], 3'b000} +: 8] = mb1_r;
    end
    if (cfg_addr_i[7:2] == ibr_pkg::OFF_APIC[7:2])
    begin
      rd_nxt[{ibr_pkg::OFF_APIC[1:0], 3'b000} +: 8] = apic_r;
      rd_nxt[{ibr_pkg::OFF_LAT[1:0], 3'b000} +: 8]  = lat_r;
    end
    if (cfg_addr_i[7:2] == ibr_pkg::OFF_DTYPE[7:2])
    begin
      rd_nxt[{ibr_pkg::OFF_DTYPE[1:0], 3'b000} +: 16]    = dtype_r;
      rd_nxt[{ibr_pkg::OFF_DBASE_LO[1:0], 3'b000} +: 16] = blo_r;
    end
    if (cfg_addr_i[7:2] == ibr_pkg::OFF_DBASE_HI[7:2])
      rd_nxt[{ibr_pkg::OFF_DBASE_HI[1:0], 3'b000} +: 16] = bhi_r;
  end

  // Register bank and read port; everything returns to default on reset.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mb0_r        <= ibr_pkg::RST_MBCTL;                          // RULE_20
      mb1_r        <= ibr_pkg::RST_MBCTL;
      apic_r       <= ibr_pkg::RST_APIC;
      lat_r        <= ibr_pkg::RST_LAT;
      dtype_r      <= ibr_pkg::RST_W16;                            // RULE_13
      blo_r        <= ibr_pkg::RST_W16;
      bhi_r        <= ibr_pkg::RST_W16;
      misc_r       <= ibr_pkg::RST_W16;
      cfg_rdata_o  <= 32'h0000_0000;
      cfg_rvalid_o <= 1'b0;
    end
    else
    begin
      mb0_r        <= mb0_nxt;
      mb1_r        <= mb1_nxt;
      apic_r       <= apic_nxt;
      lat_r        <= lat_nxt;
      dtype_r      <= dtype_nxt;
      blo_r        <= blo_nxt;
      bhi_r        <= bhi_nxt;
      misc_r       <= misc_nxt;
      cfg_rdata_o  <= cfg_rd_i ? rd_nxt : 32'h0000_0000;
      cfg_rvalid_o <= cfg_rd_i;
    end
  end

  // Fast DMA routing from both control bytes.
  logic [7:0] fast0, fast1;
  ibr_route_dec u_route0 (.ctrl_i(mb0_r), .ch_en_o(fast0));
  ibr_route_dec u_route1 (.ctrl_i(mb1_r), .ch_en_o(fast1));

  // Decode logic for APIC, distributed window and request gating.
  logic       apic_nxt_sel, dd_hit_nxt;
  logic [2:0] dd_ch_nxt;
  logic [7:0] dist_mask;
  always_comb
  begin
    apic_nxt_sel = mem_cycle_i
      && pci_addr_i[31:16] == ibr_pkg::APIC_HI
      && pci_addr_i[15:13] == apic_r[5:3]                          // RULE_03
      && (apic_r[ibr_pkg::APIC_MASK_BIT]
          || pci_addr_i[12] == apic_r[2])                          // RULE_05
      && pci_addr_i[11:10] == apic_r[1:0]                          // RULE_04
      && pci_addr_i[9:5] == 5'h00;
    dist_mask = 8'h00;
    for (int c = 0; c < 8; c++)
      dist_mask[c] = (ch_type(dtype_r, c) == ibr_pkg::DT_DIST);    // RULE_15
    dd_hit_nxt = 1'b0;
    dd_ch_nxt  = 3'h0;
    if (io_cycle_i && pci_addr_i[15:6] == blo_r[15:6])             // RULE_17
    begin
      dd_hit_nxt = 1'b1;
      dd_ch_nxt  = {1'b0, pci_addr_i[5:4]};
    end
    else if (io_cycle_i && pci_addr_i[15:6] == bhi_r[15:6]
             && pci_addr_i[5:4] != 2'h0)                           // RULE_18
    begin
      dd_hit_nxt = 1'b1;
      dd_ch_nxt  = {1'b1, pci_addr_i[5:4]};
    end
  end

  // Target latency machine: answer or force a retry inside the deadline.
  ibr_tgt_t   tst_r, tst_nxt;
  logic [4:0] tcnt_r, tcnt_nxt;
  logic       trdy_nxt, stop_nxt, arm, retried;
  always_comb
  begin
    tst_nxt  = tst_r;
    tcnt_nxt = tcnt_r;
    trdy_nxt = 1'b0;
    stop_nxt = 1'b0;
    arm      = 1'b0;
    retried  = 1'b0;
    case (tst_r)
      T_IDLE:
      begin
        if (tgt_frame_i)
        begin
          tst_nxt  = T_WAIT;
          tcnt_nxt = 5'h01;
        end
      end
      T_WAIT:
      begin
        tcnt_nxt = tcnt_r + 5'h01;
        if (tgt_data_ok_i)
        begin
          trdy_nxt = 1'b1;
          tst_nxt  = T_IDLE;
        end
        else if (tcnt_r == ibr_pkg::TGT_LAT_CLKS - 5'h02)          // RULE_12
        begin
          stop_nxt = 1'b1;
          arm      = lat_r[ibr_pkg::LAT_DT_BIT];                   // RULE_06
          tst_nxt  = arm ? T_PEND : T_IDLE;
        end
      end
      T_PEND:
      begin
        // A retry ends the wait; a discard drops the queued request.
        if (tgt_frame_i)
        begin
          retried  = 1'b1;
          tst_nxt  = T_WAIT;
          tcnt_nxt = 5'h01;
        end
        else if (tmr_exp)
          tst_nxt = T_IDLE;
      end
      default: tst_nxt = T_IDLE;
    endcase
  end

  ibr_discard_tmr #(.LIMIT(DISCARD_CLKS)) u_discard (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .arm_i     (arm),
    .clr_i     (retried),
    .busy_o    (tmr_busy),
    .expire_o  (tmr_exp)
  );

  // Master latency: ready is never held back past the data phase limit.
  logic [3:0] mcnt_r, mcnt_nxt;
  logic       mirdy_nxt;
  always_comb
  begin
    mcnt_nxt  = mst_phase_i ? mcnt_r + 4'h1 : 4'h0;
    mirdy_nxt = mst_phase_i && (mst_data_ok_i
                || mcnt_r >= ibr_pkg::MST_LAT_CLKS - 4'h2);        // RULE_12
    if (mirdy_nxt)
      mcnt_nxt = 4'h0;
  end

  // Outputs and control state.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tst_r                   <= T_IDLE;
      tcnt_r                  <= 5'h00;
      mcnt_r                  <= 4'h0;
      tgt_trdy_o              <= 1'b0;
      tgt_stop_o              <= 1'b0;
      mst_irdy_o              <= 1'b0;
      ioapic_chip_select_n_o  <= 1'b1;
      ddma_hit_o              <= 1'b0;
      ddma_chan_o             <= 3'h0;
      isa_dreq_gated_o        <= 8'h00;
      side_req_gated_o        <= 8'h00;
      fast_dma_en_o           <= 8'h00;
      dma_type_o              <= 16'h0000;
      delayed_en_o            <= 1'b0;
      bridge_hold_request_n_o <= 1'b1;
      passive_release_o       <= 1'b0;
      serr_n_o                <= 1'b1;
    end
    else
    begin
      tst_r                   <= tst_nxt;
      tcnt_r                  <= tcnt_nxt;
      mcnt_r                  <= mcnt_nxt;
      tgt_trdy_o              <= trdy_nxt;
      tgt_stop_o              <= stop_nxt;
      mst_irdy_o              <= mirdy_nxt;
      ioapic_chip_select_n_o  <= ~apic_nxt_sel;
      ddma_hit_o              <= dd_hit_nxt;
      ddma_chan_o             <= dd_ch_nxt;
      isa_dreq_gated_o        <= isa_dreq_i & ~dist_mask;          // RULE_15
      side_req_gated_o        <= side_req_i & ~dist_mask;
      fast_dma_en_o           <= fast0 | fast1;                    // RULE_01
      dma_type_o              <= dtype_r;                          // RULE_13
      delayed_en_o            <= lat_r[ibr_pkg::LAT_DT_BIT];
      bridge_hold_request_n_o <= ~hold_req_i;
      // ISA masters are trusted to wait on ready while release is on.
      passive_release_o       <= lat_r[ibr_pkg::LAT_PR_BIT] && hold_req_i
        && (!usb_access_i || lat_r[ibr_pkg::LAT_USB_BIT]);  // RULE_09 RULE_10 RULE_11
      serr_n_o <= ~(tmr_exp && lat_r[ibr_pkg::LAT_SERR_BIT]);      // RULE_08
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_frame_wait;
    tgt_frame_i && tst_r != T_PEND ##1 !tgt_data_ok_i;
  endsequence

  a_fast_route: assert property (mb0_r == 8'h81 |=> fast_dma_en_o[1]) // RULE_01
    else $error("fast dma route lost");
  a_route_off: assert property (mb0_r[2:0] == ibr_pkg::ROUTE_OFF
    && mb1_r[2:0] == ibr_pkg::ROUTE_OFF |=> fast_dma_en_o == 8'h00) // RULE_02
    else $error("disabled route enabled a channel");
  a_apic_match: assert property (mem_cycle_i && pci_addr_i == {16'hFEC0,
    apic_r[5:2], apic_r[1:0], 10'h010} |=> !ioapic_chip_select_n_o) // RULE_03
    else $error("apic window missed");
  a_apic_a12: assert property (!apic_r[6] && pci_addr_i[12] != apic_r[2]
    |=> ioapic_chip_select_n_o) // RULE_05
    else $error("apic bit 12 not compared");
  a_tgt_deadline: assert property (s_frame_wait |-> ##[0:14]
    (tgt_trdy_o || tgt_stop_o)) // RULE_12
    else $error("target missed latency limit");
  a_mst_ready: assert property ($rose(mst_phase_i) |-> ##[1:8]
    (mst_irdy_o || !mst_phase_i)) // RULE_12
    else $error("master ready too late");
  a_dt_off: assert property (!lat_r[0] && !tmr_busy |=> !tmr_busy) // RULE_06
    else $error("delayed transaction while disabled");
  a_serr_gate: assert property (tmr_exp && !lat_r[3] |=> serr_n_o) // RULE_08
    else $error("system error while disabled");
  a_serr_sticky: assert property (!serr_n_o |-> misc_r[15]) // RULE_19
    else $error("sticky error bit not set");
  a_dist_mask: assert property (dtype_r[1:0] == 2'h2 |=> !isa_dreq_gated_o[0]
    && !side_req_gated_o[0]) // RULE_15
    else $error("distributed channel took a request");
  a_no_cascade: assert property (ddma_hit_o |-> ddma_chan_o != 3'h4) // RULE_18
    else $error("cascade channel reachable");
endmodule // ibr_cfg_slice

//--- dv/ibr_pci_mst.sv
// Far-side PCI master model that opens accesses aimed at the bridge.
`timescale 1ns/1ps
module ibr_pci_mst (
  input  wire logic clk_i,   // PCI clock.
  input  wire logic trdy_i,  // Target ready pulse.
  input  wire logic stop_i,  // Target retry pulse.
  output logic      frame_o, // Frame start pulse.
  output logic      dok_o    // Data available level.
);
  // Data shows d clocks after frame, never when d is 0.
  task automatic xfer(input int d, output logic ok);
    @(posedge clk_i) frame_o <= 1'b1;
    @(posedge clk_i) frame_o <= 1'b0;
    repeat (20)
    begin
      @(posedge clk_i) dok_o <= dok_o | (d == 1);
      d--;
      #1;
      if (trdy_i | stop_i) break;
    end
    // An access left unanswered reads as unknown, so it never passes.
    ok = stop_i ? 1'b0 : trdy_i ? 1'b1 : 1'bx;
    @(posedge clk_i) dok_o <= 1'b0;
  endtask
  // Idle bus at time zero.
  initial
  begin
    frame_o = 1'b0;
    dok_o = 1'b0;
  end
endmodule // ibr_pci_mst

//--- dv/test_ibr_cfg_slice.sv
// Self-checking bench for the bridge configuration slice.
`timescale 1ns/1ps
module test_ibr_cfg_slice;
  localparam int LIM = 40; // Short discard count keeps the run brief.
  logic sys_clk_i = 0, rstn_i = 0, cfg_wr_i = 0, cfg_rd_i = 0, ok;
  logic mem_cycle_i = 0, io_cycle_i = 0, mst_phase_i = 0;
  logic mst_data_ok_i = 0, hold_req_i = 0, usb_access_i = 0;
  logic tgt_frame_i, tgt_data_ok_i, cfg_rvalid_o, ioapic_chip_select_n_o;
  logic ddma_hit_o, tgt_trdy_o, tgt_stop_o, delayed_en_o, mst_irdy_o;
  logic bridge_hold_request_n_o, passive_release_o, serr_n_o;
  logic [2:0]  ddma_chan_o;
  logic [3:0]  cfg_be_i = 0;
  logic [7:0]  cfg_addr_i = 0, isa_dreq_i = 0, side_req_i = 0;
  logic [7:0]  isa_dreq_gated_o, side_req_gated_o, fast_dma_en_o;
  logic [15:0] dma_type_o;
  logic [31:0] cfg_wdata_i = 0, pci_addr_i = 0, cfg_rdata_o, r;
  int          fails = 0, check_count = 0, n;
  logic [7:0]  ad [6] = '{8'h68, 8'h74, 8'h80, 8'h90, 8'h94, 8'hA0};
  logic [31:0] e1 [6] = '{32'h0080_0000, 32'h8787_0000, 32'h000F_007F,
                          32'hFFC0_FCFF, 32'h0000_FFC0, 32'h0};
  logic [2:0]  rt [6] = '{0, 1, 2, 5, 6, 4};
  logic [31:0] ap [6] = '{32'hFEC0_1400, 32'hFEC0_0410, 32'hFEC0_1800,
                          32'hFEC1_1400, 32'hFEC0_0400, 32'hFEC0_1410};
  logic        ae [6] = '{0, 0, 1, 1, 1, 0};
  logic [15:0] da [6] = '{16'h1020, 16'h1000, 16'h2010, 16'h2030,
                          16'h2000, 16'h1040};
  logic [3:0]  de [6] = '{4'hA, 4'h8, 4'hD, 4'hF, 4'h0, 4'h0};

  // Free-running 250 MHz clock.
  always #2 sys_clk_i = ~sys_clk_i;

  // Slice under test with a short discard timer.
  ibr_cfg_slice #(.DISCARD_CLKS(LIM)) dut (.sys_clk_i, .rstn_i, .cfg_wr_i,
    .cfg_rd_i, .cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o,
    .cfg_rvalid_o, .mem_cycle_i, .pci_addr_i, .ioapic_chip_select_n_o,
    .io_cycle_i, .ddma_hit_o, .ddma_chan_o, .isa_dreq_i, .side_req_i,
    .isa_dreq_gated_o, .side_req_gated_o, .fast_dma_en_o, .dma_type_o,
    .tgt_frame_i, .tgt_data_ok_i, .tgt_trdy_o, .tgt_stop_o, .delayed_en_o,
    .mst_phase_i, .mst_data_ok_i, .mst_irdy_o, .hold_req_i, .usb_access_i,
    .bridge_hold_request_n_o, .passive_release_o, .serr_n_o);
  ibr_pci_mst pm (.clk_i(sys_clk_i), .trdy_i(tgt_trdy_o),
    .stop_i(tgt_stop_o), .frame_o(tgt_frame_i), .dok_o(tgt_data_ok_i));

  // Compare and count; unknowns never match.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One-cycle config write strobe.
  task automatic wr(input logic [7:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    @(posedge sys_clk_i)
      {cfg_wr_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} <= {1'b1, a, b, d};
    @(posedge sys_clk_i) cfg_wr_i <= 1'b0;
  endtask
  // Read; data without its valid pulse counts as wrong.
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i) {cfg_rd_i, cfg_addr_i} <= {1'b1, a};
    @(posedge sys_clk_i) cfg_rd_i <= 1'b0;
    #1 r = (cfg_rvalid_o === 1'b1) ? cfg_rdata_o : 32'hBAD0_0BAD;
  endtask
  // Let registered outputs follow a change.
  task automatic st;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask
  // One memory (m high) or I/O address phase.
  task automatic probe(input logic m, input logic [31:0] a);
    @(posedge sys_clk_i) {mem_cycle_i, io_cycle_i, pci_addr_i} <= {m, !m, a};
    @(posedge sys_clk_i) {mem_cycle_i, io_cycle_i} <= 2'b00;
    #1;
  endtask
  task automatic summarize;
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests need.
  initial
  begin
    #100000;
    fails++;
    summarize;
  end

  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    // Reset values, then all-ones writes against masks and unmapped space.
    for (int i = 0; i < 6; i++)
    begin
      rd(ad[i]);
      chk(r, i == 1 ? 32'h0404_0000 : 32'h0);
      wr(ad[i], 4'hF, '1);
      rd(ad[i]);
      chk(r, e1[i]);
    end
    // Routable codes 0, 1, 2, 5, 6, then code 4; code 4 keeps all channels slow.
    foreach (rt[i])
    begin
      wr(8'h74, 4'hC, {8'h04, 5'h10, rt[i], 16'h0});
      st;
      chk(fast_dma_en_o, rt[i] == 4 ? 8'h0 : 8'h1 << rt[i]);
    end
    // APIC window with bit 12 ignored, then compared.
    wr(8'h80, 4'h1, 32'h45);
    foreach (ap[i])
    begin
      if (i == 4) wr(8'h80, 4'h1, 32'h05);
      probe(1'b1, ap[i]);
      chk(ioapic_chip_select_n_o, ae[i]);
    end
    // Channels 0 and 7 distributed, channel 1 sideband.
    wr(8'h90, 4'hF, 32'h1000_8006);
    wr(8'h94, 4'h3, 32'h2000);
    {isa_dreq_i, side_req_i} <= 16'hFFFF;
    st;
    chk({isa_dreq_gated_o, side_req_gated_o, dma_type_o}, 32'h7E7E_8006);
    foreach (da[i])
    begin
      probe(1'b0, {16'h0, da[i]});
      chk({ddma_hit_o, ddma_hit_o ? ddma_chan_o : 3'h0}, de[i]);
    end
    // Delayed mode with error report: an answer, then a stop never retried.
    wr(8'h80, 4'h4, 32'h0009_0000);
    st;
    chk(delayed_en_o, 1'b1);
    pm.xfer(3, ok);
    chk(ok, 1'b1);
    pm.xfer(0, ok);
    chk(ok, 1'b0);
    for (n = 0; n < 80 && serr_n_o !== 1'b0; n++)
      @(posedge sys_clk_i) #1;
    chk(n >= LIM && n <= LIM + 3, 1'b1);
    rd(8'h68);
    chk(r, 32'h8080_0000);
    wr(8'h68, 4'h8, 32'h8000_0000);
    rd(8'h68);
    chk(r, 32'h0080_0000);
    // Discard expiry with error reporting off stays silent.
    wr(8'h80, 4'h4, 32'h0001_0000);
    pm.xfer(0, ok);
    for (n = 0; n < 50 && serr_n_o !== 1'b0; n++)
      @(posedge sys_clk_i) #1;
    chk(n, 50);
    rd(8'h68);
    chk(r, 32'h0080_0000);
    // Passive release plain, USB without extension, USB with it.
    wr(8'h80, 4'h4, 32'h0002_0000);
    hold_req_i <= 1'b1;
    st;
    chk({passive_release_o, bridge_hold_request_n_o}, 2'b10);
    chk(delayed_en_o, 1'b0);
    @(posedge sys_clk_i) usb_access_i <= 1'b1;
    st;
    chk(passive_release_o, 1'b0);
    wr(8'h80, 4'h4, 32'h0006_0000);
    st;
    chk(passive_release_o, 1'b1);
    // A stop with delayed mode off must not start the discard timer.
    pm.xfer(0, ok);
    chk(ok, 1'b0);
    // Master data phase whose data never comes still gets ready in time.
    @(posedge sys_clk_i) mst_phase_i <= 1'b1;
    for (n = 0; n < 12 && mst_irdy_o !== 1'b1; n++)
      @(posedge sys_clk_i) #1;
    chk(n <= 8, 1'b1);
    @(posedge sys_clk_i) mst_data_ok_i <= 1'b1;
    st;
    chk(mst_irdy_o, 1'b1);
    summarize;
  end
endmodule // test_ibr_cfg_slice
